// File: common/addr_filter_map.svh
`ifndef ADDR_FILTER_MAP_SVH
`define ADDR_FILTER_MAP_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define SLAVE_ADDRESS_OFS      8'ha9
`define SLAVE_ADDRESS_MASK_OFS 8'hb9
`define CONTROL_OFS            8'h98
`define RX_DATA_OFS            8'h99
`define SLAVE_ADDRESS_RST      8'h00
`define SLAVE_ADDRESS_MASK_RST 8'h00

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTL_DONE_BIT     0
`define CTL_NINTH_BIT    2
`define CTL_MPE_BIT      5
`define CTL_MODE_LSB     6

`endif

// File: common/addr_filter_pkg.sv
package addr_filter_pkg;

  // Frame format selected by software
  typedef enum logic [1:0]
  {
    MODE_SYNC,
    MODE_TEN_BIT,
    MODE_NINE_FIXED,
    MODE_NINE_VAR
  } frame_mode_t;

  // Outcome of one completed frame
  typedef enum logic [1:0]
  {
    FR_IDLE,
    FR_ACCEPT,
    FR_DROP
  } frame_result_t;

endpackage : addr_filter_pkg

// File: hw/accept_gate.sv
`timescale 1ns/10ps
`default_nettype none
module accept_gate
  import addr_filter_pkg::*;
(
  // Frame context
  input  wire logic        frame_done_i,
  input  wire frame_mode_t mode_i,
  input  wire logic        multiproc_enable_i,
  input  wire logic        ninth_bit_i,
  input  wire logic        done_flag_i,
  input  wire logic        match_i,
  // Decision
  output frame_result_t    result_o
);

  wire logic nine_bit;   // Modes with a ninth data bit
  wire logic ten_bit;    // Mode where ninth bit is the stop bit
  wire logic mp_ok;      // Multiproc qualification
  wire logic accept;     // Frame is loaded

  assign nine_bit = (mode_i == MODE_NINE_FIXED) ||
                    (mode_i == MODE_NINE_VAR);
  assign ten_bit  = (mode_i == MODE_TEN_BIT);
  // Off: every frame passes; on: nine- or ten-bit mode, stop or ninth bit one, plus match
  assign mp_ok = !multiproc_enable_i ||
                 ((nine_bit || ten_bit) && ninth_bit_i
                  && match_i);
  assign accept = frame_done_i && !done_flag_i && mp_ok;
  assign result_o = !frame_done_i ? FR_IDLE :
                    (accept ? FR_ACCEPT : FR_DROP);

endmodule : accept_gate
`default_nettype wire

// File: hw/addr_match.sv
`timescale 1ns/10ps
`default_nettype none
module addr_match
  import addr_filter_pkg::*;
(
  // Programmed address and mask
  input  wire logic [7:0] slave_address_i,
  input  wire logic [7:0] slave_address_mask_i,
  // Received byte
  input  wire logic [7:0] rx_byte_i,
  // Result
  output logic            match_o
);

  // ----------------------------------------------------------------------
  // Masked compare
  // ----------------------------------------------------------------------
  // Compare only positions where care bits are one
  function automatic logic masked_eq(input logic [7:0] a,
                                     input logic [7:0] b,
                                     input logic [7:0] care);
    masked_eq = (((a ^ b) & care) == 8'h00);
  endfunction : masked_eq

  wire logic [7:0] bcast_addr;  // Address ORed with mask
  wire logic       given_hit;   // Given address hit
  wire logic       bcast_hit;   // Broadcast hit

  assign given_hit  = masked_eq(rx_byte_i, slave_address_i,
                                slave_address_mask_i);
  assign bcast_addr = slave_address_i | slave_address_mask_i;
  // Zeros of the OR are ignored, so the care mask is the OR itself
  assign bcast_hit  = masked_eq(rx_byte_i, bcast_addr, bcast_addr);
  assign match_o    = given_hit | bcast_hit;

endmodule : addr_match
`default_nettype wire

// File: hw/serial_address_recognition.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "addr_filter_map.svh"
module serial_address_recognition
  import addr_filter_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // Receiver shifter side
  input  wire logic       frame_done_i,
  input  wire logic [7:0] frame_byte_i,
  input  wire logic       frame_ninth_i,
  // Status to the core
  output logic            receive_done_flag_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_ninth_o,
  output logic            frame_drop_o
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]  slave_address_ff;       // Programmed address
  logic [7:0]  slave_address_mask_ff;  // Address care mask
  logic        multiproc_enable_ff;    // Address filtering on
  frame_mode_t mode_ff;                // Frame format
  logic        done_flag_ff;           // Receive done, sticky
  logic [7:0]  rx_data_ff;             // Last accepted byte
  logic        rx_ninth_ff;            // Its ninth or stop bit
  logic        drop_ff;                // One-cycle drop pulse
  logic [7:0]  rdata_ff;               // Read data, one cycle late

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire logic sel_addr;   // Address register hit
  wire logic sel_mask;   // Mask register hit
  wire logic sel_ctl;    // Control register hit
  wire logic sel_data;   // Data register hit
  wire logic [7:0] ctl_view;   // Control readback
  wire logic [7:0] rd_mux;     // Selected read value
  wire logic match;            // Address hit
  frame_result_t result;       // Frame decision
  wire logic nxt_done_flag;    // Next flag value

  assign sel_addr = (reg_addr_i == `SLAVE_ADDRESS_OFS);
  assign sel_mask = (reg_addr_i == `SLAVE_ADDRESS_MASK_OFS);
  assign sel_ctl  = (reg_addr_i == `CONTROL_OFS);
  assign sel_data = (reg_addr_i == `RX_DATA_OFS);

  assign ctl_view = {mode_ff, multiproc_enable_ff, 2'h0,
                     rx_ninth_ff, 1'b0, done_flag_ff};

  // Unmapped addresses read as zero
  assign rd_mux = sel_addr ? slave_address_ff :
                  sel_mask ? slave_address_mask_ff :
                  sel_ctl  ? ctl_view :
                  sel_data ? rx_data_ff : 8'h00;

  // ----------------------------------------------------------------------
  // Frame filter
  // ----------------------------------------------------------------------
  addr_match u_match
  (
    .slave_address_i      (slave_address_ff),
    .slave_address_mask_i (slave_address_mask_ff),
    .rx_byte_i            (frame_byte_i),
    .match_o              (match)
  );

  accept_gate u_gate
  (
    .frame_done_i       (frame_done_i),
    .mode_i             (mode_ff),
    .multiproc_enable_i (multiproc_enable_ff),
    .ninth_bit_i        (frame_ninth_i),
    .done_flag_i        (done_flag_ff),
    .match_i            (match),
    .result_o           (result)
  );

  // Hardware set wins over a software clear in the same cycle
  assign nxt_done_flag = (result == FR_ACCEPT) ? 1'b1 :
                         (reg_wr_i && sel_ctl) ?
                           reg_wdata_i[`CTL_DONE_BIT] : done_flag_ff;

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  // Address and mask clear to don't-care everywhere on reset
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      slave_address_ff      <= `SLAVE_ADDRESS_RST;
      slave_address_mask_ff <= `SLAVE_ADDRESS_MASK_RST;
    end
    else if (reg_wr_i && sel_addr)
    begin
      slave_address_ff <= reg_wdata_i;
    end
    else if (reg_wr_i && sel_mask)
    begin
      slave_address_mask_ff <= reg_wdata_i;
    end
  end

  // Control register: mode and filter enable
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      multiproc_enable_ff <= 1'b0;
      mode_ff             <= MODE_SYNC;
    end
    else if (reg_wr_i && sel_ctl)
    begin
      multiproc_enable_ff <= reg_wdata_i[`CTL_MPE_BIT];
      mode_ff <= frame_mode_t'(reg_wdata_i[`CTL_MODE_LSB +: 2]);
    end
  end

  // ----------------------------------------------------------------------
  // Receive side state
  // ----------------------------------------------------------------------
  // Data only updates on an accepted frame; a dropped one is lost
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      done_flag_ff <= 1'b0;
      rx_data_ff   <= 8'h00;
      rx_ninth_ff  <= 1'b0;
      drop_ff      <= 1'b0;
    end
    else
    begin
      done_flag_ff <= nxt_done_flag;
      drop_ff      <= (result == FR_DROP);
      if (result == FR_ACCEPT)
      begin
        rx_data_ff  <= frame_byte_i;
        rx_ninth_ff <= frame_ninth_i;
      end
    end
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      rdata_ff <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata_o         = rdata_ff;
  assign receive_done_flag_o = done_flag_ff;
  assign rx_data_o           = rx_data_ff;
  assign rx_ninth_o          = rx_ninth_ff;
  assign frame_drop_o        = drop_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_mp_no_match_no_flag;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (frame_done_i && multiproc_enable_ff && !match && !done_flag_ff
     && !(reg_wr_i && sel_ctl)) |=> !receive_done_flag_o;
  endproperty
  a_mp_no_match_no_flag: assert property (p_mp_no_match_no_flag)
    else $error("flag raised for unmatched address frame");

  property p_plain_sets_flag;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (frame_done_i && !multiproc_enable_ff && !done_flag_ff)
      |=> (receive_done_flag_o && rx_data_o == $past(frame_byte_i));
  endproperty
  a_plain_sets_flag: assert property (p_plain_sets_flag)
    else $error("plain frame not accepted");

  property p_stop_zero_dropped;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (frame_done_i && multiproc_enable_ff && !frame_ninth_i)
      |=> frame_drop_o;
  endproperty
  a_stop_zero_dropped: assert property (p_stop_zero_dropped)
    else $error("frame with ninth bit zero accepted");

  property p_given_hit;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (((frame_byte_i ^ slave_address_ff) & slave_address_mask_ff)
      == 8'h00) |-> match;
  endproperty
  a_given_hit: assert property (p_given_hit)
    else $error("given address not recognised");

  property p_bcast_hit;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ((frame_byte_i & (slave_address_ff | slave_address_mask_ff))
      == (slave_address_ff | slave_address_mask_ff)) |-> match;
  endproperty
  a_bcast_hit: assert property (p_bcast_hit)
    else $error("broadcast address not recognised");

  property p_addr_write;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (reg_wr_i && reg_addr_i == 8'ha9) |=>
      (slave_address_ff == $past(reg_wdata_i));
  endproperty
  a_addr_write: assert property (p_addr_write)
    else $error("address register write lost");

  property p_readback;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (reg_rd_i && reg_addr_i == 8'hb9) |=>
      (reg_rdata_o == slave_address_mask_ff);
  endproperty
  a_readback: assert property (p_readback)
    else $error("mask readback wrong");

  property p_flag_blocks_load;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (frame_done_i && done_flag_ff) |=>
      (frame_drop_o && $stable(rx_data_o));
  endproperty
  a_flag_blocks_load: assert property (p_flag_blocks_load)
    else $error("frame loaded while flag set");

  property p_reset_match_all;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (slave_address_mask_ff == 8'h00 && slave_address_ff == 8'h00)
      |-> match;
  endproperty
  a_reset_match_all: assert property (p_reset_match_all)
    else $error("cleared registers do not match all");

  // Independent of the gate: a qualified address frame must load
  property p_accept_loads;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (frame_done_i && multiproc_enable_ff && mode_ff != MODE_SYNC
     && frame_ninth_i && match && !done_flag_ff)
      |=> (receive_done_flag_o && rx_data_o == $past(frame_byte_i));
  endproperty
  a_accept_loads: assert property (p_accept_loads)
    else $error("matched address frame not accepted");

  // Sync frames carry no ninth bit, so filtering drops them all
  property p_sync_mp_drops;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (frame_done_i && multiproc_enable_ff && mode_ff == MODE_SYNC)
      |=> frame_drop_o;
  endproperty
  a_sync_mp_drops: assert property (p_sync_mp_drops)
    else $error("sync frame accepted under filtering");

  // A software clear must never cancel a same-cycle hardware set
  property p_set_wins;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (result == FR_ACCEPT) |=> receive_done_flag_o;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("accepted frame did not raise the flag");

  property p_drop_keeps_data;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (result == FR_DROP) |=> ($stable(rx_data_o) && $stable(rx_ninth_o));
  endproperty
  a_drop_keeps_data: assert property (p_drop_keeps_data)
    else $error("dropped frame changed the received data");

  property p_no_frame_no_drop;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !frame_done_i |=> !frame_drop_o;
  endproperty
  a_no_frame_no_drop: assert property (p_no_frame_no_drop)
    else $error("drop pulse without a frame");

  // Register side: idle read data and the mask write
  property p_rdata_zero_idle;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !reg_rd_i |=> (reg_rdata_o == 8'h00);
  endproperty
  a_rdata_zero_idle: assert property (p_rdata_zero_idle)
    else $error("read data not zero outside a read");

  property p_mask_write;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (reg_wr_i && reg_addr_i == 8'hb9) |=>
      (slave_address_mask_ff == $past(reg_wdata_i));
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask register write lost");

endmodule : serial_address_recognition
`default_nettype wire

// File: verification/frame_source.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Remote master model: hands over one completed frame per call
// ----------------------------------------------------------------------
module frame_source
(
  // Clock
  input  wire logic       sys_clk_i,
  // Frame lines toward the filter
  output logic            frame_done_o,
  output logic      [7:0] frame_byte_o,
  output logic            frame_ninth_o
);

  // Quiet lines at time zero
  initial
  begin
    frame_done_o  = 1'b0;
    frame_byte_o  = 8'h00;
    frame_ninth_o = 1'b0;
  end

  // One frame for one cycle; callers mark address frames with ninth set
  task automatic send(input logic [7:0] b, input logic n);
    @(posedge sys_clk_i);
    frame_done_o  <= 1'b1;
    frame_byte_o  <= b;
    frame_ninth_o <= n;
    @(posedge sys_clk_i);
    // Stale lines are inverted so a late sample cannot pass by luck
    frame_done_o  <= 1'b0;
    frame_byte_o  <= ~b;
    frame_ninth_o <= ~n;
  endtask : send

endmodule : frame_source
`default_nettype wire

// File: verification/serial_address_recognition_test.sv
`timescale 1ns/10ps
`default_nettype none
// Compare two values, count, and report a mismatch at once
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
  fail_count++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
  end end
module serial_address_recognition_test;
  import addr_filter_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic       sys_clk_i;            // 50 MHz clock
  logic       reset_n_i;            // Active low reset
  logic [7:0] reg_addr_i;           // Register address
  logic [7:0] reg_wdata_i;          // Register write data
  logic       reg_wr_i;             // Write strobe
  logic       reg_rd_i;             // Read strobe
  logic [7:0] reg_rdata_o;          // Read data
  logic       frame_done;           // Frame handed over
  logic [7:0] frame_byte;           // Frame data bits
  logic       frame_ninth;          // Ninth or stop bit
  logic       receive_done_flag_o;  // Sticky receive-done flag
  logic [7:0] rx_data_o;            // Accepted byte
  logic       rx_ninth_o;           // Accepted ninth bit
  logic       frame_drop_o;         // Rejected frame pulse
  int         fail_count = 0;       // Mismatches seen
  int         compares   = 0;       // Comparisons made
  int         cycles     = 0;       // Watchdog count
  logic [7:0] ab [5] = '{8'ha0, 8'ha5, 8'ha2, 8'hff, 8'h7e}; // Addresses
  logic       ok [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};      // Accepted?

  // ----------------------------------------------------------------------
  // Design, far side and clock
  // ----------------------------------------------------------------------
  serial_address_recognition DUT (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .frame_done_i(frame_done),
    .frame_byte_i(frame_byte), .frame_ninth_i(frame_ninth),
    .receive_done_flag_o(receive_done_flag_o), .rx_data_o(rx_data_o),
    .rx_ninth_o(rx_ninth_o), .frame_drop_o(frame_drop_o));
  frame_source src (.sys_clk_i(sys_clk_i), .frame_done_o(frame_done),
    .frame_byte_o(frame_byte), .frame_ninth_o(frame_ninth));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // Watchdog: the whole run needs about 90 cycles
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    #1 `CHK(reg_rdata_o, exp)
  endtask : rd

  // Send a frame, then check the decision made at its taking edge
  task automatic frm(input logic [7:0] b, input logic n, input logic acc,
                     input logic fl);
    src.send(b, n);
    #1 `CHK(frame_drop_o, ~acc)
    `CHK(receive_done_flag_o, fl)
    if (acc)
    begin
      `CHK(rx_data_o, b)
      `CHK(rx_ninth_o, n)
    end
  endtask : frm

  task automatic final_report();
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    reset_n_i   = 1'b0;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rd(8'ha9, 8'h00);
    rd(8'hb9, 8'h00);
    rd(8'h55, 8'h00);
    // Nine-bit mode, multiproc on while waiting for an address
    wr(8'h98, 8'ha0);
    frm(8'h3c, 1'b1, 1'b1, 1'b1);
    // Flag still set: the next frame is lost
    frm(8'h11, 1'b1, 1'b0, 1'b1);
    `CHK(rx_data_o, 8'h3c)
    rd(8'h99, 8'h3c);
    rd(8'h98, 8'ha5);
    wr(8'h98, 8'ha0);
    wr(8'ha9, 8'ha4);
    wr(8'hb9, 8'hfa);
    rd(8'ha9, 8'ha4);
    rd(8'hb9, 8'hfa);
    // Given, don't-care, mismatch and broadcast addresses
    for (int i = 0; i < 5; i++)
    begin
      frm(ab[i], 1'b1, ok[i], ok[i]);
      wr(8'h98, 8'ha0);
    end
    frm(8'ha0, 1'b0, 1'b0, 1'b0);
    // Ten-bit mode needs a stop bit of one and a match
    wr(8'h98, 8'h60);
    frm(8'ha0, 1'b0, 1'b0, 1'b0);
    frm(8'ha0, 1'b1, 1'b1, 1'b1);
    wr(8'h98, 8'h60);
    frm(8'ha2, 1'b1, 1'b0, 1'b0);
    // Multiproc off: every frame is taken
    wr(8'h98, 8'h40);
    frm(8'ha2, 1'b0, 1'b1, 1'b1);
    // Sync mode drops all frames under multiproc; nine-bit variant filters
    wr(8'h98, 8'h20);
    frm(8'ha0, 1'b1, 1'b0, 1'b0);
    wr(8'h98, 8'he0);
    frm(8'hff, 1'b1, 1'b1, 1'b1);
    rd(8'h98, 8'he5);
    // Mid-run reset returns both registers to match-all
    reset_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    `CHK(receive_done_flag_o, 1'b0)
    rd(8'ha9, 8'h00);
    rd(8'hb9, 8'h00);
    final_report();
  end

endmodule : serial_address_recognition_test
`default_nettype wire
